// ===== pkg/cgcr_regs.svh
// register offsets, field positions, reset values and rate figures for the router
`ifndef CGCR_REGS_SVH
`define CGCR_REGS_SVH
`define CGCR_OFS_CTRL0   8'h20
`define CGCR_OFS_CTRL1   8'h22
`define CGCR_OFS_CTRL2   8'h24
`define CGCR_OFS_RATE    8'h26
`define CGCR_CSRC_LSB    0
`define CGCR_CEDGE_BIT   2
`define CGCR_CQ_BIT      3
`define CGCR_GSRC_LSB    4
`define CGCR_GPOL_BIT    6
`define CGCR_GQ_BIT      7
`define CGCR_GR_BIT      8
`define CGCR_CTRL_RST    8'h00
`define CGCR_RATE_RST    2'h0
`define CGCR_SRC_SOFT    2'h0
`define CGCR_SRC_ALT     2'h1
`define CGCR_SRC_PIN     2'h2
`define CGCR_SRC_CHAIN   2'h3
`define CGCR_SYS_KHZ     25000
`define CGCR_RATE0_KHZ   10000
`define CGCR_RATE1_KHZ   1000
`define CGCR_RATE2_KHZ   100
`define CGCR_RATE3_KHZ   10
`endif

// ===== pkg/cgcr_pkg.sv
// types shared by the counter gate and clock router
package cgcr_pkg;
  typedef enum logic [1:0] {MEAS_DONE, MEAS_ARMED, MEAS_PASS} cgcr_meas_t;
  typedef struct packed {
    logic [2:0][7:0]   ctrl;
    logic [2:0]        rearm;
    logic [1:0]        rate;
    logic [15:0]       nco_acc;
    logic              int_clk;
    logic [2:0][2:0]   clk_sync;
    logic [2:0][2:0]   gate_sync;
    logic [2:0][2:0]   out_sync;
    logic [2:0]        clk_filt;
    logic [2:0]        gate_filt;
    logic [2:0]        out_filt;
    logic [2:0][1:0]   meas;
    logic [2:0]        clk_out;
    logic [2:0]        gate_out;
    logic [15:0]       rdata;
  } cgcr_state_t;
endpackage

// ===== verilog/cgcr_router.sv
// clock and gate routing, measurement gating and status for three interval counters
`timescale 1ns/1ps
// Behaviour
// RULE1 - clock source field: 00 soft level, 01 internal, 10 pin, 11 preceding output
// RULE2 - chained clocks: 0 from 2, 2 from 1, 1 from 0
// RULE3 - source 10 takes each counter's own external clock pin
// RULE4 - internal clock from shared rate field: 10MHz, 1MHz, 100KHz, 10KHz
// RULE5 - clock edge bit: 0 rising, 1 falling edge presented to counter
// RULE6 - soft clock source: written level drives counter clock, giving edges
// RULE7 - gate source field: 00 soft level, 01 preceding output, 10 pin, 11 measurement
// RULE8 - chained gates: 0 from 2, 1 from 0, 2 from 1
// RULE9 - gate source 10 takes each counter's own external gate pin
// RULE10 - gate polarity bit: 0 positive, 1 inverted
// RULE11 - soft gate source: written level holds the gate
// RULE12 - measurement passes one positive cycle, then blocks until rearmed
// RULE13 - software rearms measurement with a rising edge before the signal arrives
// RULE14 - status bit shows each counter's gate level
// RULE15 - status bit shows each counter's output level
// RULE16 - status bit shows each counter's clock level
// RULE17 - busy bit is 1 while measurement runs, 0 once complete
// RULE18 - control bits 8..0, status 11..8 on read, rate write-only bits 1..0
// RULE19 - routing fields and soft levels clear to zero on reset
// RULE20 - rewriting the same soft clock level makes no edge
// RULE21 - counter 0 paces the D/A output, counter 1 the A/D
`include "cgcr_regs.svh"
module cgcr_router (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // connector pins
  input  wire logic [2:0]  ext_counter_clock_pin,
  input  wire logic [2:0]  ext_counter_gate_pin,
  // counter side
  input  wire logic [2:0]  counter_result_level,
  output logic      [2:0]  counter_clock_level,
  output logic      [2:0]  gate_input_level,
  output logic             dac_pacer,
  output logic             adc_pacer
);
  import cgcr_pkg::*;

  cgcr_state_t st_reg;
  cgcr_state_t st_next;
  logic [15:0] nco_sum;
  logic [2:0]  rearm_pulse;
  logic [2:0]  meas_level;
  logic [2:0]  clk_src;
  logic [2:0]  gate_src;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic pick4(input logic [1:0] sel, input logic a, input logic b,
                                 input logic c, input logic d);
    case (sel)
      `CGCR_SRC_SOFT: pick4 = a;
      `CGCR_SRC_ALT:  pick4 = b;
      `CGCR_SRC_PIN:  pick4 = c;
      default:        pick4 = d;
    endcase
  endfunction

  function automatic int prev_idx(input int i);
    prev_idx = (i + 2) % 3;
  endfunction

  function automatic logic [15:0] rate_inc(input logic [1:0] r);
    case (r)
      2'h0:    rate_inc = 16'(2 * `CGCR_RATE0_KHZ);
      2'h1:    rate_inc = 16'(2 * `CGCR_RATE1_KHZ);
      2'h2:    rate_inc = 16'(2 * `CGCR_RATE2_KHZ);
      default: rate_inc = 16'(2 * `CGCR_RATE3_KHZ);
    endcase
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next     = st_reg;
    rearm_pulse = 3'h0;
    meas_level  = 3'h0;
    clk_src     = 3'h0;
    gate_src    = 3'h0;
    // pin synchronisers, level accepted once stages two and three agree
    for (int i = 0; i < 3; i++) begin
      st_next.clk_sync[i]  = {st_reg.clk_sync[i][1:0], ext_counter_clock_pin[i]};
      st_next.gate_sync[i] = {st_reg.gate_sync[i][1:0], ext_counter_gate_pin[i]};
      st_next.out_sync[i]  = {st_reg.out_sync[i][1:0], counter_result_level[i]};
      if (st_reg.clk_sync[i][1] == st_reg.clk_sync[i][2]) begin
        st_next.clk_filt[i] = st_reg.clk_sync[i][2];
      end
      if (st_reg.gate_sync[i][1] == st_reg.gate_sync[i][2]) begin
        st_next.gate_filt[i] = st_reg.gate_sync[i][2];
      end
      if (st_reg.out_sync[i][1] == st_reg.out_sync[i][2]) begin
        st_next.out_filt[i] = st_reg.out_sync[i][2];
      end
    end
    // internal clock: fractional divider toggling at twice the chosen rate
    nco_sum = st_reg.nco_acc + rate_inc(st_reg.rate);  // [RULE4]
    if (nco_sum >= 16'(`CGCR_SYS_KHZ)) begin
      st_next.nco_acc = nco_sum - 16'(`CGCR_SYS_KHZ);
      st_next.int_clk = ~st_reg.int_clk;
    end else begin
      st_next.nco_acc = nco_sum;
    end
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `CGCR_OFS_CTRL0, `CGCR_OFS_CTRL1, `CGCR_OFS_CTRL2: begin
          for (int i = 0; i < 3; i++) begin
            if (reg_addr == 8'(`CGCR_OFS_CTRL0 + 2 * i)) begin
              st_next.ctrl[i]  = reg_wdata[7:0];  // [RULE18]
              rearm_pulse[i]   = reg_wdata[`CGCR_GR_BIT] & ~st_reg.rearm[i];  // [RULE12]
              st_next.rearm[i] = reg_wdata[`CGCR_GR_BIT];
            end
          end
        end
        `CGCR_OFS_RATE: begin
          st_next.rate = reg_wdata[1:0];  // [RULE18]
        end
        default: begin
        end
      endcase
    end
    // measurement gating per counter
    for (int i = 0; i < 3; i++) begin
      case (cgcr_meas_t'(st_reg.meas[i]))
        MEAS_DONE: begin
          if (rearm_pulse[i]) begin
            st_next.meas[i] = MEAS_ARMED;
          end
        end
        MEAS_ARMED: begin
          if (!rearm_pulse[i] && !st_reg.gate_filt[i] && st_next.gate_filt[i]) begin
            st_next.meas[i] = MEAS_PASS;  // [RULE12]
          end
        end
        MEAS_PASS: begin
          if (rearm_pulse[i]) begin
            st_next.meas[i] = MEAS_ARMED;
          end else if (!st_next.gate_filt[i]) begin
            st_next.meas[i] = MEAS_DONE;  // [RULE12]
          end
        end
        default: begin
          st_next.meas[i] = MEAS_DONE;
        end
      endcase
      meas_level[i] = (st_next.meas[i] == MEAS_PASS) & st_next.gate_filt[i];
    end
    // routing, soft levels follow the write in the same step  [RULE6] [RULE11] [RULE20]
    for (int i = 0; i < 3; i++) begin
      clk_src[i] = pick4(st_next.ctrl[i][`CGCR_CSRC_LSB+:2], st_next.ctrl[i][`CGCR_CQ_BIT],
                         st_next.int_clk, st_next.clk_filt[i],
                         st_next.out_filt[prev_idx(i)]);  // [RULE1] [RULE2] [RULE3]
      gate_src[i] = pick4(st_next.ctrl[i][`CGCR_GSRC_LSB+:2], st_next.ctrl[i][`CGCR_GQ_BIT],
                          st_next.out_filt[prev_idx(i)], st_next.gate_filt[i],
                          meas_level[i]);  // [RULE7] [RULE8] [RULE9]
      st_next.clk_out[i]  = clk_src[i] ^ st_next.ctrl[i][`CGCR_CEDGE_BIT];  // [RULE5]
      st_next.gate_out[i] = gate_src[i] ^ st_next.ctrl[i][`CGCR_GPOL_BIT];  // [RULE10]
    end
    // register reads, rate word reads back as zero
    if (reg_rd) begin
      st_next.rdata = 16'h0000;
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == 8'(`CGCR_OFS_CTRL0 + 2 * i)) begin
          st_next.rdata = {4'h0, st_reg.meas[i] != MEAS_DONE, st_reg.clk_out[i],
                           st_reg.out_filt[i], st_reg.gate_out[i],
                           st_reg.ctrl[i]};  // [RULE14] [RULE15] [RULE16] [RULE17]
        end
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg      <= '0;
      st_reg.ctrl <= {3{`CGCR_CTRL_RST}};  // [RULE19]
      st_reg.rate <= `CGCR_RATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata           = st_reg.rdata;
  assign counter_clock_level = st_reg.clk_out;
  assign gate_input_level    = st_reg.gate_out;
  assign dac_pacer           = st_reg.out_filt[0];  // [RULE21]
  assign adc_pacer           = st_reg.out_filt[1];  // [RULE21]

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  soft_clock_a: assert property ( // [RULE6]
    reg_wr && reg_addr == `CGCR_OFS_CTRL0 && reg_wdata[3:0] == 4'h0 |=> counter_clock_level[0] == 1'b0)
    else $error("soft clock low not driven");

  soft_clock_hi_a: assert property ( // [RULE20]
    reg_wr && reg_addr == `CGCR_OFS_CTRL2 && reg_wdata[3:0] == 4'h8 ##2
    reg_wr && reg_addr == `CGCR_OFS_CTRL2 && reg_wdata[3:0] == 4'h8 |=> $stable(counter_clock_level[2]))
    else $error("repeated soft clock write made an edge");

  soft_gate_a: assert property ( // [RULE11]
    reg_wr && reg_addr == `CGCR_OFS_CTRL2 && reg_wdata[7:4] == 4'h0 |=> gate_input_level[2] == 1'b0)
    else $error("soft gate low not held");

  int_edge_a: assert property ( // [RULE5]
    st_reg.ctrl[2][3:0] == 4'h5 && $stable(st_reg.ctrl[2]) |-> counter_clock_level[2] == ~st_reg.int_clk)
    else $error("inverted internal clock wrong");

  int_rate_a: assert property ( // [RULE4]
    st_reg.rate == 2'h0 && $stable(st_reg.rate) |-> ##[1:2] $changed(st_reg.int_clk))
    else $error("fast internal clock stalled");

  pin_clock_a: assert property ( // [RULE3]
    st_reg.ctrl[2][3:0] == 4'h2 && $stable(st_reg.ctrl[2]) |-> counter_clock_level[2] == st_reg.clk_filt[2])
    else $error("pin clock not routed");

  ring_clock_a: assert property ( // [RULE2]
    st_reg.ctrl[1][3:0] == 4'h3 && $stable(st_reg.ctrl[1]) |-> counter_clock_level[1] == st_reg.out_filt[0])
    else $error("counter 1 not clocked by counter 0");

  ring_gate_a: assert property ( // [RULE8]
    st_reg.ctrl[1][7:4] == 4'h1 && $stable(st_reg.ctrl[1]) |-> gate_input_level[1] == st_reg.out_filt[0])
    else $error("counter 1 gate not from counter 0");

  pin_gate_a: assert property ( // [RULE9]
    st_reg.ctrl[2][7:4] == 4'h2 && $stable(st_reg.ctrl[2]) |-> gate_input_level[2] == st_reg.gate_filt[2])
    else $error("pin gate not routed");

  meas_once_a: assert property ( // [RULE12]
    st_reg.meas[0] == MEAS_DONE && !(reg_wr && reg_addr == `CGCR_OFS_CTRL0) |=> st_reg.meas[0] == MEAS_DONE)
    else $error("measurement left done without rearm");

  busy_read_a: assert property ( // [RULE17]
    reg_rd && reg_addr == `CGCR_OFS_CTRL2 |=> reg_rdata[11] == ($past(st_reg.meas[2]) != MEAS_DONE))
    else $error("busy status wrong");

  level_read_a: assert property ( // [RULE16]
    reg_rd && reg_addr == `CGCR_OFS_CTRL0 |=>
    reg_rdata[10:8] == {$past(counter_clock_level[0]), $past(st_reg.out_filt[0]), $past(gate_input_level[0])})
    else $error("level status wrong");

  rate_read_a: assert property ( // [RULE18]
    reg_rd && reg_addr == `CGCR_OFS_RATE |=> reg_rdata == 16'h0000)
    else $error("rate word not write-only");

  pass_cov: cover property (st_reg.meas[1] == MEAS_ARMED ##[1:50] st_reg.meas[1] == MEAS_PASS);
  done_cov: cover property (st_reg.meas[1] == MEAS_PASS ##[1:50] st_reg.meas[1] == MEAS_DONE);
  ring_cov: cover property (st_reg.ctrl[1][1:0] == 2'h3 && $rose(counter_clock_level[1]));
  soft_cov: cover property ($rose(counter_clock_level[0]) && st_reg.ctrl[0][1:0] == 2'h0);
endmodule

// ===== sim/cgcr_counter_model.sv
// behavioural stand-in for the three interval counters behind the router
`timescale 1ns/1ps
module cgcr_counter_model (
  // counter inputs
  rst_n,
  clk_in,
  gate_in,
  // counter outputs
  out
);
  input  wire logic       rst_n;
  input  wire logic [2:0] clk_in;
  input  wire logic [2:0] gate_in;
  output logic      [2:0] out;
  logic             [2:0] gate_dly;
  // gate as it stood just before the clock edge, so a gate rising with the clock does not count
  assign #1 gate_dly = gate_in;
  // each counter halves its clock while gated on
  for (genvar i = 0; i < 3; i++) begin : g_cnt
    always @(posedge clk_in[i] or negedge rst_n) begin
      if (!rst_n) out[i] <= 1'b0;
      else if (gate_dly[i]) out[i] <= ~out[i];
    end
  end
endmodule

// ===== sim/test_cgcr_router.sv
// self-checking bench for the counter gate and clock router
`timescale 1ns/1ps
`include "cgcr_regs.svh"
module test_cgcr_router;
  logic        clock = 1'b1;
  logic        rst_n = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [2:0]  cpin = 3'h0;
  logic [2:0]  gpin = 3'h0;
  logic [2:0]  cres, clk_lvl, gate_lvl;
  logic        dac_pacer, adc_pacer;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n, exp_n;
  logic        prev;
  cgcr_router u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_counter_clock_pin(cpin), .ext_counter_gate_pin(gpin),
    .counter_result_level(cres), .counter_clock_level(clk_lvl), .gate_input_level(gate_lvl),
    .dac_pacer(dac_pacer), .adc_pacer(adc_pacer));
  cgcr_counter_model u_cnt (.rst_n(rst_n), .clk_in(clk_lvl), .gate_in(gate_lvl), .out(cres));
  initial forever #20 clock = ~clock;
  // ****************
  // tasks
  // ****************
  task automatic stop_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    chk(reg_rdata, e);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    wt(1);
    rst_n = 1'b0;
    wt(20);
    rst_n = 1'b1;
    wt(1);
    chk({10'h0, clk_lvl, gate_lvl}, 16'h0000);
    rd(`CGCR_OFS_CTRL0, 16'h0000);
    rd(`CGCR_OFS_CTRL2, 16'h0000);
    $display("test reset done");
    wr(`CGCR_OFS_CTRL0, 16'h0080);
    wr(`CGCR_OFS_CTRL0, 16'h0088);
    wt(8);
    wr(`CGCR_OFS_CTRL1, 16'h0013);
    wt(8);
    chk({12'h0, clk_lvl[1], gate_lvl[1], dac_pacer, adc_pacer}, 16'h000E);
    rd(`CGCR_OFS_CTRL0, 16'h0788);
    $display("test chain done");
    wr(`CGCR_OFS_CTRL2, 16'h0008);
    chk({15'h0, clk_lvl[2]}, 16'h0001);
    wr(`CGCR_OFS_CTRL2, 16'h0008);
    chk({15'h0, clk_lvl[2]}, 16'h0001);
    wr(`CGCR_OFS_CTRL2, 16'h0000);
    chk({15'h0, clk_lvl[2]}, 16'h0000);
    wr(`CGCR_OFS_CTRL2, 16'h0004);
    chk({15'h0, clk_lvl[2]}, 16'h0001);
    wr(`CGCR_OFS_CTRL2, 16'h0080);
    chk({14'h0, clk_lvl[2], gate_lvl[2]}, 16'h0001);
    wr(`CGCR_OFS_CTRL2, 16'h00C0);
    chk({15'h0, gate_lvl[2]}, 16'h0000);
    wr(`CGCR_OFS_CTRL2, 16'h0040);
    chk({15'h0, gate_lvl[2]}, 16'h0001);
    $display("test soft levels done");
    wr(`CGCR_OFS_CTRL2, 16'h0022);
    cpin = 3'h4;
    gpin = 3'h4;
    wt(8);
    chk({14'h0, clk_lvl[2], gate_lvl[2]}, 16'h0003);
    cpin = 3'h3;
    gpin = 3'h3;
    wt(8);
    chk({14'h0, clk_lvl[2], gate_lvl[2]}, 16'h0000);
    cpin = 3'h0;
    gpin = 3'h0;
    $display("test pins done");
    for (int r = 0; r < 4; r++) begin
      wr(`CGCR_OFS_CTRL2, (r < 2) ? 16'h0001 : 16'h0005);
      wr(`CGCR_OFS_RATE, 16'(r));
      exp_n = (r == 0) ? 1000 : (r == 1) ? 100 : (r == 2) ? 10 : 1;
      n = 0;
      prev = clk_lvl[2];
      repeat (2500) begin
        @(negedge clock);
        if (clk_lvl[2] && !prev) n++;
        prev = clk_lvl[2];
      end
      chk({15'h0, n >= exp_n - 1 && n <= exp_n + 1}, 16'h0001);
    end
    $display("test rates done");
    wr(`CGCR_OFS_CTRL0, 16'h0130);
    rd(`CGCR_OFS_CTRL0, 16'h0A30);
    gpin = 3'h1;
    wt(8);
    chk({15'h0, gate_lvl[0]}, 16'h0001);
    gpin = 3'h0;
    wt(8);
    chk({15'h0, gate_lvl[0]}, 16'h0000);
    rd(`CGCR_OFS_CTRL0, 16'h0230);
    gpin = 3'h1;
    wt(8);
    chk({15'h0, gate_lvl[0]}, 16'h0000);
    gpin = 3'h0;
    wr(`CGCR_OFS_CTRL0, 16'h0030);
    wr(`CGCR_OFS_CTRL0, 16'h0130);
    gpin = 3'h1;
    wt(8);
    chk({15'h0, gate_lvl[0]}, 16'h0001);
    gpin = 3'h0;
    $display("test measurement done");
    wr(8'h28, 16'hFFFF);
    rd(8'h28, 16'h0000);
    rd(`CGCR_OFS_RATE, 16'h0000);
    $display("test map done");
    stop_test();
  end
endmodule
